// ===== bench/actuator_driver_io_config_bench.sv
// self-checking bench for the io configuration front end
`timescale 1ns/1ps
module actuator_driver_io_config_bench;
  logic clk, rst, cyc, stb, we, ack, busy, err, prot, supply;
  logic baud_ok, modbus, a_led, c_led, e_led, p_led;
  logic [7:0] adr, term;
  logic [3:0] sel, axis_sw, baud_sw, lanes;
  logic [31:0] wdat, rdat, q;
  logic [1:0] fsw;
  logic [4:0] axis;
  logic [19:0] rate;
  logic [15:0] shape;
  adio_pkg::adio_req_t req;
  int n_fail, check_count, i;
  int cnt [8];
  int tb [4] = '{0, 1, 6, 7};
  int rb [4] = '{7, 6, 5, 4};

  adio_io_config #(.BLINK_HALF(4)) u_dut (.clk_i(clk), .rst_i(rst),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .axis_number_switch_i(axis_sw), .baud_select_switch_i(baud_sw),
    .function_switch_i(fsw), .input_terminal_i(term),
    .supply_ok_i(supply), .protective_active_i(prot),
    .comm_busy_i(busy), .comm_err_i(err), .axis_number_o(axis),
    .baud_rate_o(rate), .baud_valid_o(baud_ok), .modbus_mode_o(modbus),
    .req_o(req), .alarm_led_o(a_led), .comm_activity_led_o(c_led),
    .comm_err_led_o(e_led), .power_led_o(p_led));

  adio_host_model u_host (.clk_i(clk), .term_o(term), .busy_o(busy),
    .err_o(err), .prot_o(prot), .supply_o(supply));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // count request pulses so a held pin that repeats is caught
  always @(posedge clk) begin
    for (int k = 4; k < 8; k++) if (req[k] === 1'b1) cnt[k]++;
  end

  task automatic give_verdict();
    $display("checks %0d failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  // one classic cycle; request held until ack is seen at an edge
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] r);
    int j;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= lanes;
    j = 0;
    do begin
      @(posedge clk);
      j++;
    end while (ack !== 1'b1 && j < 20);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (ack !== 1'b1) begin
      n_fail++;
      give_verdict();
    end
  endtask

  function automatic logic [19:0] exp_rate(input int c);
    case (c)
      0: return 20'h02580;
      1: return 20'h04b00;
      2: return 20'h09600;
      3: return 20'h0e100;
      4: return 20'h1c200;
      7: return 20'h98968;
      default: return 20'h00000;
    endcase
  endfunction

  // shipped values must hide the pins until the synchronisers fill
  task automatic t_reset();
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk(rate, 20'h98968);
    chk(axis, 5'h00);
    chk(modbus, 1'b0);
    tick(3);
    chk(axis, 5'h15);
    chk(modbus, 1'b1);
  endtask

  task automatic t_switch();
    for (i = 0; i < 16; i++) begin
      @(posedge clk);
      baud_sw <= i[3:0];
      tick(4);
      chk(rate, exp_rate(i));
      chk(baud_ok, exp_rate(i) != 20'h0);
    end
    @(posedge clk);
    axis_sw <= 4'ha;
    fsw <= 2'b10;
    tick(4);
    chk(axis, 5'h0a);
    chk(modbus, 1'b1);
  endtask

  // error must stay lit after the event until software clears it
  task automatic t_leds();
    u_host.set_line(4'b1001);
    tick(3);
    chk(c_led, 1'b1);
    u_host.set_line(4'b0000);
    tick(4);
    chk({c_led, p_led}, 2'b00);
    u_host.set_line(4'b0101);
    u_host.set_line(4'b0001);
    tick(4);
    chk({e_led, p_led}, 2'b11);
    wb(1'b0, 8'h08, 32'h0, q);
    chk(q[18], 1'b1);
    // an error in the same cycle as the clear write must win
    fork
      wb(1'b1, 8'h0c, 32'h1, q);
      begin
        u_host.set_line(4'b0101);
        u_host.set_line(4'b0001);
      end
    join
    tick(2);
    chk(e_led, 1'b1);
    wb(1'b1, 8'h0c, 32'h1, q);
    tick(2);
    chk(e_led, 1'b0);
  endtask

  task automatic t_blink();
    u_host.set_line(4'b0011);
    i = 0;
    while (a_led !== 1'b1 && i < 10) begin
      @(negedge clk);
      i++;
    end
    chk(i < 10, 1'b1);
    if (i >= 10) give_verdict();
    for (int k = 0; k < 16; k++) begin
      shape = {shape[14:0], a_led};
      @(negedge clk);
    end
    chk(shape, 16'hf0f0);
    u_host.set_line(4'b0001);
    tick(3);
    chk(a_led, 1'b0);
  endtask

  task automatic t_terms();
    for (i = 0; i < 4; i++) begin
      cnt = '{default: 0};
      u_host.set_term(8'h01 << tb[i]);
      tick(6);
      u_host.set_term(8'h00);
      tick(4);
      chk(cnt[rb[i]], 1);
      chk(cnt[4] + cnt[5] + cnt[6] + cnt[7], 1);
    end
    u_host.set_term(8'h20);
    tick(4);
    chk(req.free, 1'b1);
    u_host.set_term(8'h00);
    tick(4);
    chk(req.free, 1'b0);
    for (i = 0; i < 8; i++) begin
      u_host.set_data(i[2:0]);
      tick(4);
      chk(req.data_sel, i[2:0]);
    end
  endtask

  // code 54 refused on its lane, 53 kept, terminal 0 moved to free
  task automatic t_assign();
    wb(1'b0, 8'h04, 32'h0, q);
    chk(q, 32'h18121032);
    wb(1'b1, 8'h00, 32'h36350410, q);
    wb(1'b0, 8'h00, 32'h0, q);
    chk(q, 32'h31350410);
    u_host.set_term(8'h01);
    tick(4);
    chk(req.free, 1'b1);
    u_host.set_term(8'h00);
    wb(1'b0, 8'h20, 32'h0, q);
    chk(q, 32'h0);
    // only the selected lane is written
    lanes = 4'h1;
    wb(1'b1, 8'h04, 32'h0, q);
    lanes = 4'hf;
    wb(1'b0, 8'h04, 32'h0, q);
    chk(q, 32'h18121000);
  endtask

  initial begin
    rst = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    wdat = 32'h0;
    lanes = 4'hf;
    axis_sw = 4'h5;
    baud_sw = 4'h2;
    fsw = 2'b11;
    n_fail = 0;
    check_count = 0;
    shape = 16'h0;
    t_reset();
    t_switch();
    t_leds();
    t_blink();
    t_terms();
    t_assign();
    give_verdict();
  end
endmodule

// ===== bench/adio_host_model.sv
// host controller model driving terminals and serial status lines
`timescale 1ns/1ps
module adio_host_model (
  input wire logic clk_i,
  output logic [7:0] term_o,
  output logic busy_o,
  output logic err_o,
  output logic prot_o,
  output logic supply_o
);
  // quiet lines with supply present from time zero
  initial begin
    term_o = 8'h00;
    busy_o = 1'b0;
    err_o = 1'b0;
    prot_o = 1'b0;
    supply_o = 1'b1;
  end

  // each terminal is a plain level; the block gives it its meaning
  task automatic set_term(input logic [7:0] v);
    @(posedge clk_i);
    term_o <= v;
  endtask

  // data number sits on terminals 2..4, lowest bit on terminal 2
  task automatic set_data(input logic [2:0] n);
    @(posedge clk_i);
    term_o <= {3'h0, n, 2'h0};
  endtask

  // busy, error, protective and supply levels in one go
  task automatic set_line(input logic [3:0] v);
    @(posedge clk_i);
    busy_o <= v[3];
    err_o <= v[2];
    prot_o <= v[1];
    supply_o <= v[0];
  endtask
endmodule

// ===== hdl/adio_io_config.sv
// switch, indicator and input terminal front end with wishbone registers
`timescale 1ns/1ps
`include "adio_regs.svh"

// Contract
// - baud code 7 gives 625000 bps for the network converter
// - baud switch reads code 7 until first sample after reset
// - axis switch gives the station number, shipped value zero
// - function switch bit one extends the axis number, shipped off
// - function switch bit two picks modbus rtu when on, shipped off
// - alarm led blinks while a protective function is active
// - comm activity led lit while serial data moves
// - comm error led lights once a serial error is detected
// - power led lit while the supply is present
// - each terminal holds a function code, zero unused, up to 53
// - three terminals form the 3-bit data number, default terminals 2-4
// - terminal 0 requests homing by default
// - terminal 5 frees the motor and brake by default
module adio_io_config #(
  parameter int unsigned BLINK_HALF =
    `ADIO_BLINK_MS * (`ADIO_CLK_HZ / `ADIO_MS_PER_S)
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [3:0] axis_number_switch_i,
  input wire logic [3:0] baud_select_switch_i,
  input wire logic [1:0] function_switch_i,
  input wire logic [7:0] input_terminal_i,
  input wire logic supply_ok_i,
  input wire logic protective_active_i,
  input wire logic comm_busy_i,
  input wire logic comm_err_i,
  output logic [4:0] axis_number_o,
  output logic [19:0] baud_rate_o,
  output logic baud_valid_o,
  output logic modbus_mode_o,
  output adio_pkg::adio_req_t req_o,
  output logic alarm_led_o,
  output logic comm_activity_led_o,
  output logic comm_err_led_o,
  output logic power_led_o
);

  localparam logic [18:0] SYNC_RST = {1'b0, `ADIO_PROTO_SHIP,
    `ADIO_EXT_SHIP, `ADIO_AXIS_SHIP, `ADIO_BAUD_SHIP, 8'h00};
  localparam adio_pkg::adio_state_t RST_ST = '{
    s1: SYNC_RST, s2: SYNC_RST, prev: 4'h0, req: '0,
    asg_lo: `ADIO_ASSIGN_LO_RST, asg_hi: `ADIO_ASSIGN_HI_RST,
    err: 1'b0, act: 1'b0, blink_cnt: 32'h0, blink: 1'b1,
    alarm: 1'b0, ack: 1'b0, dat: 32'h0};

  adio_pkg::adio_state_t st;
  adio_pkg::adio_state_t next_st;

  // speed for a baud switch code, zero for unused codes
  function automatic logic [19:0] rate_of(input logic [3:0] c);
    logic [19:0] r;
    r = 20'h0;
    unique case (c)
      `ADIO_BAUD_C0: r = `ADIO_RATE_C0;
      `ADIO_BAUD_C1: r = `ADIO_RATE_C1;
      `ADIO_BAUD_C2: r = `ADIO_RATE_C2;
      `ADIO_BAUD_C3: r = `ADIO_RATE_C3;
      `ADIO_BAUD_C4: r = `ADIO_RATE_C4;
      `ADIO_BAUD_C7: r = `ADIO_RATE_C7;
      default: r = 20'h0;
    endcase
    return r;
  endfunction

  // true when any high terminal is assigned the given function
  function automatic logic fn_on(input logic [63:0] asg,
                                 input logic [7:0] t,
                                 input logic [5:0] code);
    logic r;
    r = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (t[i] && asg[8*i +: 8] == {2'h0, code}) begin
        r = 1'b1;
      end
    end
    return r;
  endfunction

  // merge a register write, dropping lanes with codes beyond the range
  function automatic logic [31:0] asg_wr(input logic [31:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i] && wd[8*i +: 8] <= `ADIO_FN_MAX) begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return r;
  endfunction

  // every lane of an assignment word holds a legal code
  function automatic logic asg_ok(input logic [31:0] w);
    logic r;
    r = 1'b1;
    for (int i = 0; i < 4; i++) begin
      if (w[8*i +: 8] > `ADIO_FN_MAX) begin
        r = 1'b0;
      end
    end
    return r;
  endfunction

  logic [7:0] term;
  logic [3:0] baud_code;
  logic [63:0] asg;
  logic [3:0] fn_now;
  logic wr;
  logic rd_ok;

  // synchronised switch and terminal fields, all taken from the second flop
  assign term = st.s2[7:0];
  assign baud_code = st.s2[11:8];
  assign asg = {st.asg_hi, st.asg_lo};
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !st.ack;
  assign rd_ok = wb_cyc_i && wb_stb_i && !st.ack;

  // level of the edge-triggered functions: home, start, stop, fault clear
  assign fn_now = {fn_on(asg, term, `ADIO_FN_FCLR),
                   fn_on(asg, term, `ADIO_FN_STOP),
                   fn_on(asg, term, `ADIO_FN_START),
                   fn_on(asg, term, `ADIO_FN_HOME)};

  // next state
  always_comb begin
    next_st = st;
    // switch, terminal and supply pins pass two flops before anything reads them
    next_st.s1 = {supply_ok_i, function_switch_i[1], function_switch_i[0],
                  axis_number_switch_i, baud_select_switch_i,
                  input_terminal_i};
    next_st.s2 = st.s1;

    // home, start, stop and fault clear fire once per rising input so a held pin does not repeat
    next_st.prev = fn_now;
    next_st.req.home = fn_now[0] && !st.prev[0];
    next_st.req.start = fn_now[1] && !st.prev[1];
    next_st.req.stop = fn_now[2] && !st.prev[2];
    next_st.req.fault_clear = fn_now[3] && !st.prev[3];
    next_st.req.free = fn_on(asg, term, `ADIO_FN_FREE);
    next_st.req.data_sel = {fn_on(asg, term, `ADIO_FN_DS2),
                            fn_on(asg, term, `ADIO_FN_DS1),
                            fn_on(asg, term, `ADIO_FN_DS0)};

    // comm indicators; a new error beats a clear in the same cycle
    next_st.act = comm_busy_i;
    if (wr && wb_adr_i == `ADIO_A_CONTROL &&
        wb_sel_i[0] && wb_dat_i[`ADIO_CTL_ERR_CLR]) begin
      next_st.err = 1'b0;
    end
    if (comm_err_i) begin
      next_st.err = 1'b1;
    end

    // alarm blink restarts lit so a new fault shows at once
    if (!protective_active_i) begin
      next_st.blink_cnt = 32'h0;
      next_st.blink = 1'b1;
    end else if (st.blink_cnt >= 32'(BLINK_HALF - 1)) begin
      next_st.blink_cnt = 32'h0;
      next_st.blink = !st.blink;
    end else begin
      next_st.blink_cnt = st.blink_cnt + 32'h1;
    end
    next_st.alarm = protective_active_i && st.blink;

    // assignment writes
    if (wr && wb_adr_i == `ADIO_A_ASSIGN_LO) begin
      next_st.asg_lo = asg_wr(st.asg_lo, wb_dat_i, wb_sel_i);
    end
    if (wr && wb_adr_i == `ADIO_A_ASSIGN_HI) begin
      next_st.asg_hi = asg_wr(st.asg_hi, wb_dat_i, wb_sel_i);
    end

    // one wait state per access; unmapped reads give zero
    next_st.ack = rd_ok;
    next_st.dat = 32'h0;
    if (rd_ok && !wb_we_i) begin
      unique case (wb_adr_i)
        `ADIO_A_ASSIGN_LO: next_st.dat = st.asg_lo;
        `ADIO_A_ASSIGN_HI: next_st.dat = st.asg_hi;
        `ADIO_A_STATUS: next_st.dat = {12'h0, st.s2[18], st.err,
                                       st.s2[17], st.s2[16:12], st.s2[11:0]};
        `ADIO_A_RATE: next_st.dat = {baud_valid_o, 11'h0, baud_rate_o};
        default: next_st.dat = 32'h0;
      endcase
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= RST_ST; // shipped switch values until the pins are sampled
    end else begin
      st <= next_st;
    end
  end

  // outputs
  assign wb_ack_o = st.ack;
  assign wb_dat_o = st.dat;
  assign axis_number_o = st.s2[16:12];
  assign baud_rate_o = rate_of(baud_code);
  assign baud_valid_o = baud_rate_o != 20'h0;
  assign modbus_mode_o = st.s2[17];
  assign req_o = st.req;
  assign alarm_led_o = st.alarm;
  assign comm_activity_led_o = st.act;
  assign comm_err_led_o = st.err;
  assign power_led_o = st.s2[18];

  // code 7 always maps to the converter rate
  baud_conv_a: assert property (@(posedge clk_i) disable iff (rst_i)
    baud_code == `ADIO_BAUD_C7 |-> baud_rate_o == `ADIO_RATE_C7)
    else $error("baud code 7 not 625000");

  // right after reset the shipped speed is in force
  ship_baud_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(rst_i) |-> baud_rate_o == `ADIO_RATE_C7)
    else $error("shipped baud rate wrong");

  // shipped axis, extension bit and protocol
  ship_axis_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(rst_i) |-> axis_number_o == 5'h00 && !modbus_mode_o)
    else $error("shipped axis or protocol wrong");

  // protocol follows its switch two flops later
  proto_sync_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !$past(rst_i) && !$past(rst_i, 2) |->
      modbus_mode_o == $past(function_switch_i[1], 2))
    else $error("protocol switch not synchronised");

  // alarm led lit one cycle after a fault starts
  alarm_led_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(protective_active_i) |=> alarm_led_o)
    else $error("alarm led not lit at fault start");

  // alarm led dark the cycle after the fault ends
  alarm_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !protective_active_i |=> !alarm_led_o)
    else $error("alarm led lit without a fault");

  // activity led tracks traffic with one cycle of latency
  comm_led_a: assert property (@(posedge clk_i) disable iff (rst_i)
    comm_busy_i |=> comm_activity_led_o)
    else $error("activity led not lit");

  // error flag set even when cleared in the same cycle
  err_sticky_a: assert property (@(posedge clk_i) disable iff (rst_i)
    comm_err_i |=> comm_err_led_o)
    else $error("comm error lost");

  // power led follows a steady supply; the reset flops need two edges
  power_led_a: assert property (@(posedge clk_i) disable iff (rst_i)
    supply_ok_i [*3] ##0 (!$past(rst_i) && !$past(rst_i, 2)) |-> power_led_o)
    else $error("power led not lit");

  // power led dark once the supply has been gone a while
  power_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !supply_ok_i [*3] |-> !power_led_o)
    else $error("power led lit without supply");

  // activity led dark the cycle after traffic stops
  act_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !comm_busy_i |=> !comm_activity_led_o)
    else $error("activity led lit without traffic");

  // error flag never sets without an error event
  err_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !comm_err_led_o && !comm_err_i |=> !comm_err_led_o)
    else $error("comm error led lit without an error");

  // slowest and fastest plain codes decode to their speeds
  baud_slow_a: assert property (@(posedge clk_i) disable iff (rst_i)
    baud_code == `ADIO_BAUD_C0 |-> baud_rate_o == `ADIO_RATE_C0)
    else $error("baud code 0 decoded wrong");

  baud_fast_a: assert property (@(posedge clk_i) disable iff (rst_i)
    baud_code == `ADIO_BAUD_C4 |-> baud_rate_o == `ADIO_RATE_C4)
    else $error("baud code 4 decoded wrong");

  // axis number follows its switches two flops later
  axis_sync_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !$past(rst_i) && !$past(rst_i, 2) |->
      axis_number_o == {$past(function_switch_i[0], 2),
                        $past(axis_number_switch_i, 2)})
    else $error("axis switch not synchronised");

  // every access is answered in the next cycle
  ack_wait_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus access not answered");

  // acknowledge lasts one cycle even with the strobe held
  ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge longer than one cycle");

  // no request is pending right after reset
  req_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(rst_i) |-> req_o == '0)
    else $error("request pending after reset");

  // assignments never hold a code beyond the range
  asg_range_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> asg_ok(st.asg_lo) && asg_ok(st.asg_hi))
    else $error("illegal function code stored");

  // homing request lasts one cycle
  home_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    req_o.home |=> !req_o.home)
    else $error("home request longer than one cycle");

  // start, stop and fault clear requests last one cycle each
  start_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    req_o.start |=> !req_o.start)
    else $error("start request longer than one cycle");

  stop_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    req_o.stop |=> !req_o.stop)
    else $error("stop request longer than one cycle");

  fclr_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    req_o.fault_clear |=> !req_o.fault_clear)
    else $error("fault clear request longer than one cycle");

endmodule

// ===== hdl/adio_pkg.sv
// types shared by the actuator driver io configuration block
package adio_pkg;

  // function requests decoded from the input terminals
  typedef struct packed {
    logic home;
    logic start;
    logic stop;
    logic fault_clear;
    logic free;
    logic [2:0] data_sel;
  } adio_req_t;

  // whole state of the block
  typedef struct packed {
    logic [18:0] s1;
    logic [18:0] s2;
    logic [3:0] prev;
    adio_req_t req;
    logic [31:0] asg_lo;
    logic [31:0] asg_hi;
    logic err;
    logic act;
    logic [31:0] blink_cnt;
    logic blink;
    logic alarm;
    logic ack;
    logic [31:0] dat;
  } adio_state_t;

endpackage

// ===== hdl/adio_regs.svh
// register offsets, function codes, shipped switch values and timing
`ifndef ADIO_REGS_SVH
`define ADIO_REGS_SVH

// register byte offsets on the wishbone slave
`define ADIO_A_ASSIGN_LO 8'h00
`define ADIO_A_ASSIGN_HI 8'h04
`define ADIO_A_STATUS 8'h08
`define ADIO_A_CONTROL 8'h0c
`define ADIO_A_RATE 8'h10

// terminal function codes
`define ADIO_FN_UNUSED 6'h00
`define ADIO_FN_HOME 6'h03
`define ADIO_FN_START 6'h04
`define ADIO_FN_FREE 6'h10
`define ADIO_FN_STOP 6'h12
`define ADIO_FN_FCLR 6'h18
`define ADIO_FN_DS0 6'h30
`define ADIO_FN_DS1 6'h31
`define ADIO_FN_DS2 6'h32
`define ADIO_FN_MAX 8'h35

// default assignment: t3..t0 = ds1 ds0 start home, t7..t4 = fclr stop free ds2
`define ADIO_ASSIGN_LO_RST 32'h31300403
`define ADIO_ASSIGN_HI_RST 32'h18121032

// shipped switch settings
`define ADIO_BAUD_SHIP 4'h7
`define ADIO_AXIS_SHIP 4'h0
`define ADIO_EXT_SHIP 1'b0
`define ADIO_PROTO_SHIP 1'b0

// baud codes and rates in bits per second
`define ADIO_BAUD_C0 4'h0
`define ADIO_BAUD_C1 4'h1
`define ADIO_BAUD_C2 4'h2
`define ADIO_BAUD_C3 4'h3
`define ADIO_BAUD_C4 4'h4
`define ADIO_BAUD_C7 4'h7
`define ADIO_RATE_C0 20'h02580
`define ADIO_RATE_C1 20'h04b00
`define ADIO_RATE_C2 20'h09600
`define ADIO_RATE_C3 20'h0e100
`define ADIO_RATE_C4 20'h1c200
`define ADIO_RATE_C7 20'h98968

// control register: write one clears the comm error flag
`define ADIO_CTL_ERR_CLR 0

// clock rate in hz (40 mhz) and alarm blink half period in ms (500)
`define ADIO_CLK_HZ 32'h02625a00
`define ADIO_BLINK_MS 32'h000001f4
`define ADIO_MS_PER_S 32'h000003e8

`endif
